// *** inc/pmca_pkg.sv ***
// Constants, field layouts and state types of the power monitor calculation and alert block
package pmca_pkg;

  // ==========================================================================
  // Clock, widths and arithmetic scaling
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned CT_W         = 24;
  localparam int unsigned ACC_W        = 27;
  localparam int unsigned AVG_CNT_W    = 10;
  localparam int unsigned CUR_SHIFT    = 11;
  localparam int unsigned PWR_SHIFT    = 14;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SHUNT  = 8'h01;
  localparam logic [7:0] ADDR_BUS    = 8'h02;
  localparam logic [7:0] ADDR_POWER  = 8'h03;
  localparam logic [7:0] ADDR_CURR   = 8'h04;
  localparam logic [7:0] ADDR_CAL    = 8'h05;
  localparam logic [7:0] ADDR_MEN    = 8'h06;
  localparam logic [7:0] ADDR_LIMIT  = 8'h07;

  // ==========================================================================
  // Configuration fields and reset values
  localparam int unsigned CFG_MODE_LO  = 0;
  localparam int unsigned CFG_SHCT_LO  = 3;
  localparam int unsigned CFG_BUSCT_LO = 6;
  localparam int unsigned CFG_AVG_LO   = 9;
  localparam int unsigned MODE_SHUNT   = 0;
  localparam int unsigned MODE_BUS     = 1;
  localparam int unsigned MODE_CONT    = 2;
  localparam logic [15:0] CFG_RESET    = 16'h4127;
  localparam logic [15:0] CAL_RESET    = 16'h0000;
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] MEN_RESET    = 16'h0000;

  // ==========================================================================
  // Mask and enable bits
  localparam int unsigned MEN_SOL  = 15;
  localparam int unsigned MEN_SUL  = 14;
  localparam int unsigned MEN_BOL  = 13;
  localparam int unsigned MEN_BUL  = 12;
  localparam int unsigned MEN_POL  = 11;
  localparam int unsigned MEN_READY_ON_ALERT_ENABLE = 10;
  localparam int unsigned MEN_AFF  = 4;
  localparam int unsigned MEN_CONVERSION_READY_FLAG = 3;
  localparam int unsigned MEN_ALERT_POLARITY = 1;
  localparam int unsigned MEN_LEN  = 0;
  localparam logic [15:0] MEN_WR_MASK = 16'hFC03;

  // ==========================================================================
  // Conversion times in microseconds, as printed
  localparam int unsigned CT0_US = 140;
  localparam int unsigned CT1_US = 204;
  localparam int unsigned CT2_US = 332;
  localparam int unsigned CT3_US = 588;
  localparam int unsigned CT4_US = 1100;
  localparam int unsigned CT5_US = 2116;
  localparam int unsigned CT6_US = 4156;
  localparam int unsigned CT7_US = 8244;

  // Conversion time of one code
  function automatic int unsigned ct_us(input logic [2:0] code);
    int unsigned t;
    case (code)
      3'h0: t = CT0_US;
      3'h1: t = CT1_US;
      3'h2: t = CT2_US;
      3'h3: t = CT3_US;
      3'h4: t = CT4_US;
      3'h5: t = CT5_US;
      3'h6: t = CT6_US;
      default: t = CT7_US;
    endcase
    return t;
  endfunction

  // Log2 of the number of averages of one code
  function automatic logic [3:0] avg_log2(input logic [2:0] code);
    logic [3:0] s;
    case (code)
      3'h0: s = 4'h0;
      3'h1: s = 4'h2;
      3'h2: s = 4'h4;
      3'h3: s = 4'h6;
      3'h4: s = 4'h7;
      3'h5: s = 4'h8;
      3'h6: s = 4'h9;
      default: s = 4'hA;
    endcase
    return s;
  endfunction

  // ==========================================================================
  // Sequencer states and the whole block state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHUNT = 2'b01,
    ST_BUS   = 2'b10
  } pmca_state_type;

  typedef struct packed {
    pmca_state_type        state;
    logic [CT_W-1:0]       ct_cnt;
    logic [AVG_CNT_W-1:0]  avg_cnt;
    logic [15:0]           cfg;
    logic [15:0]           cal;
    logic [15:0]           limit;
    logic [15:0]           men;
    logic                  aff;
    logic                  conversion_ready_flag;
    logic [15:0]           last_cur;
    logic [ACC_W-1:0]      acc_sh;
    logic [ACC_W-1:0]      acc_bus;
    logic [ACC_W-1:0]      acc_cur;
    logic [ACC_W-1:0]      acc_pwr;
    logic [15:0]           shunt_reg;
    logic [15:0]           bus_reg;
    logic [15:0]           cur_reg;
    logic [15:0]           pwr_reg;
    logic [15:0]           rdata;
    logic                  alert_oe;
  } pmca_regs_type;

endpackage

// *** design/pmca_core.sv ***
// Calculation, averaging, register file and alert logic of the power monitor
//
// Contract
// - Current from shunt sample and calibration, zero uncalibrated
// - Power from previous current and bus sample
// - Calculations never lengthen the conversion period
// - Results accumulate until averaging count; one goes direct
// - Averaged shunt, bus, current, power load together
// - Five limit checks share one limit register
// - Open-drain alert asserts when selected check violates
// - Highest set enable bit wins among checks
// - Ready may share alert; host reads flags
// - Without ready enable alert follows limit check only
// - Shunt checks compare after every shunt conversion
// - Alert function flag high on limit violation
// - Alert active level follows polarity bit one
// - Latched flag holds until config write, mask read
// - Bus checks compare after every bus conversion
// - Power check compares after every bus conversion
// - Shunt and bus conversion times independently selectable
// - Mode 111 converts shunt then bus repeatedly
// - Ready flag sets at run end, clears as documented
module pmca_core
  import pmca_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CLK_FREQ_MHZ
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic [15:0] adc_result_in,
  output logic             adc_busy_out,
  output logic             adc_chan_bus_out,
  output logic             alert_pin_out,
  output logic             alert_pin_oe_out
);

  // ==========================================================================
  // Helpers
  // Cycles of one conversion, less one for a down counter
  function automatic logic [CT_W-1:0] ct_cycles(input logic [2:0] code);
    return CT_W'(ct_us(code) * CYC_PER_US - 1);
  endfunction

  // Signed saturation to 16 bits
  function automatic logic [15:0] sat_s16(input logic signed [32:0] v);
    logic [15:0] r;
    if (v > 33'sd32767) begin
      r = 16'h7FFF;
    end else if (v < -33'sd32768) begin
      r = 16'h8000;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  // Unsigned saturation to 16 bits
  function automatic logic [15:0] sat_u16(input logic [32:0] v);
    return (v[32:16] != 17'h0) ? 16'hFFFF : v[15:0];
  endfunction

  // Signed accumulator average
  function automatic logic [15:0] avg_s(input logic [ACC_W-1:0] sum, input logic [3:0] sh);
    logic signed [ACC_W-1:0] t;
    t = $signed(sum) >>> sh;
    return t[15:0];
  endfunction

  // ==========================================================================
  // State
  pmca_regs_type q;
  pmca_regs_type n;

  logic                   cfg_wr;
  logic                   men_rd;
  logic [2:0]             mode;
  logic [3:0]             avg_sh;
  logic                   conv_end;
  logic                   shunt_end;
  logic                   bus_end;
  logic                   seq_end;
  logic                   run_done;
  logic signed [32:0]     cur_prod;
  logic [15:0]            cur_calc;
  logic [15:0]            cur_abs;
  logic [32:0]            pwr_prod;
  logic [15:0]            pwr_calc;
  logic [ACC_W-1:0]       sum_sh;
  logic [ACC_W-1:0]       sum_bus;
  logic [ACC_W-1:0]       sum_cur;
  logic [ACC_W-1:0]       sum_pwr;
  logic                   sel_sol;
  logic                   sel_sul;
  logic                   sel_bol;
  logic                   sel_bul;
  logic                   sel_pol;
  logic                   cmp_valid;
  logic                   cmp_viol;
  logic                   alert_act;
  logic [AVG_CNT_W-1:0]   avg_last;

  // ==========================================================================
  // Decode, arithmetic and limit selection
  always_comb begin
    cfg_wr    = reg_wr_in && (reg_addr_in == ADDR_CONFIG);
    men_rd    = reg_rd_in && (reg_addr_in == ADDR_MEN);
    mode      = q.cfg[CFG_MODE_LO +: 3];
    avg_sh    = avg_log2(q.cfg[CFG_AVG_LO +: 3]);
    avg_last  = AVG_CNT_W'((32'h1 << avg_sh) - 32'h1);
    // Conversion ends while the counter sits at zero
    conv_end  = (q.state != ST_IDLE) && (q.ct_cnt == '0);
    shunt_end = conv_end && (q.state == ST_SHUNT);
    bus_end   = conv_end && (q.state == ST_BUS);
    seq_end   = (shunt_end && !mode[MODE_BUS]) || bus_end;
    run_done  = seq_end && (q.avg_cnt == avg_last);
    // Current in the same cycle the sample is taken, no extra latency
    cur_prod  = 33'($signed(adc_result_in) * $signed({1'b0, q.cal}));
    cur_calc  = (q.cal == CAL_RESET) ? 16'h0000 : sat_s16(cur_prod >>> CUR_SHIFT);
    // Power from the preceding current and the bus sample
    cur_abs   = q.last_cur[15] ? 16'(-q.last_cur) : q.last_cur;
    pwr_prod  = 33'(cur_abs * adc_result_in);
    pwr_calc  = (q.cal == CAL_RESET) ? 16'h0000 : sat_u16(pwr_prod >> PWR_SHIFT);
    // Running sums including the present sample
    sum_sh    = q.acc_sh + ACC_W'($signed(adc_result_in));
    sum_bus   = q.acc_bus + ACC_W'(adc_result_in);
    sum_cur   = q.acc_cur + ACC_W'($signed(cur_calc));
    sum_pwr   = q.acc_pwr + ACC_W'(pwr_calc);
    // One check at a time, highest enable bit first
    sel_sol   = q.men[MEN_SOL];
    sel_sul   = !q.men[MEN_SOL] && q.men[MEN_SUL];
    sel_bol   = !(|q.men[MEN_SOL:MEN_SUL]) && q.men[MEN_BOL];
    sel_bul   = !(|q.men[MEN_SOL:MEN_BOL]) && q.men[MEN_BUL];
    sel_pol   = !(|q.men[MEN_SOL:MEN_BUL]) && q.men[MEN_POL];
    cmp_valid = (shunt_end && (sel_sol || sel_sul)) || (bus_end && (sel_bol || sel_bul || sel_pol));
    cmp_viol  = 1'b0;
    if (shunt_end && sel_sol) begin
      cmp_viol = $signed(adc_result_in) > $signed(q.limit);
    end else if (shunt_end && sel_sul) begin
      cmp_viol = $signed(adc_result_in) < $signed(q.limit);
    end else if (bus_end && sel_bol) begin
      cmp_viol = adc_result_in > q.limit;
    end else if (bus_end && sel_bul) begin
      cmp_viol = adc_result_in < q.limit;
    end else if (bus_end && sel_pol) begin
      cmp_viol = pwr_calc > q.limit;
    end
    // Ready shares the pin only when enabled
    alert_act = q.aff || (q.men[MEN_READY_ON_ALERT_ENABLE] && q.conversion_ready_flag);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    n = q;
    // Conversion sequencer
    if (q.state != ST_IDLE && q.ct_cnt != '0) begin
      n.ct_cnt = q.ct_cnt - CT_W'(1);
    end
    if (shunt_end) begin
      n.last_cur = cur_calc;
      n.acc_sh   = sum_sh;
      n.acc_cur  = sum_cur;
    end
    if (bus_end) begin
      n.acc_bus = sum_bus;
      n.acc_pwr = sum_pwr;
    end
    if (shunt_end && mode[MODE_BUS]) begin
      n.state  = ST_BUS;
      n.ct_cnt = ct_cycles(q.cfg[CFG_BUSCT_LO +: 3]);
    end else if (seq_end) begin
      n.avg_cnt = q.avg_cnt + AVG_CNT_W'(1);
      if (run_done) begin
        // Load all converted quantities together, one sample goes direct
        n.avg_cnt = '0;
        n.acc_sh  = '0;
        n.acc_bus = '0;
        n.acc_cur = '0;
        n.acc_pwr = '0;
        if (mode[MODE_SHUNT]) begin
          n.shunt_reg = avg_s(shunt_end ? sum_sh : q.acc_sh, avg_sh);
          n.cur_reg   = avg_s(shunt_end ? sum_cur : q.acc_cur, avg_sh);
        end
        if (mode[MODE_BUS]) begin
          n.bus_reg = avg_s(sum_bus, avg_sh);
          n.pwr_reg = avg_s(sum_pwr, avg_sh);
        end
      end
      if (run_done && !mode[MODE_CONT]) begin
        n.state = ST_IDLE;
      end else if (mode[MODE_SHUNT]) begin
        n.state  = ST_SHUNT;
        n.ct_cnt = ct_cycles(q.cfg[CFG_SHCT_LO +: 3]);
      end else begin
        n.state  = ST_BUS;
        n.ct_cnt = ct_cycles(q.cfg[CFG_BUSCT_LO +: 3]);
      end
    end
    // Register writes; a configuration write restarts the sequence
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_CONFIG: n.cfg   = reg_wdata_in;
        ADDR_CAL:    n.cal   = reg_wdata_in;
        ADDR_LIMIT:  n.limit = reg_wdata_in;
        ADDR_MEN:    n.men   = reg_wdata_in & MEN_WR_MASK;
        default:     n.cal   = q.cal;
      endcase
    end
    if (cfg_wr) begin
      n.avg_cnt = '0;
      n.acc_sh  = '0;
      n.acc_bus = '0;
      n.acc_cur = '0;
      n.acc_pwr = '0;
      if (reg_wdata_in[CFG_MODE_LO + MODE_SHUNT]) begin
        n.state  = ST_SHUNT;
        n.ct_cnt = ct_cycles(reg_wdata_in[CFG_SHCT_LO +: 3]);
      end else if (reg_wdata_in[CFG_MODE_LO + MODE_BUS]) begin
        n.state  = ST_BUS;
        n.ct_cnt = ct_cycles(reg_wdata_in[CFG_BUSCT_LO +: 3]);
      end else begin
        n.state  = ST_IDLE;
      end
    end
    // Alert function flag: latched or following
    if (q.men[MEN_LEN]) begin
      if (cfg_wr || men_rd) begin
        n.aff = 1'b0;
      end
      if (cmp_valid && cmp_viol) begin
        n.aff = 1'b1;
      end
    end else if (cmp_valid) begin
      n.aff = cmp_viol;
    end
    // Conversion ready flag, set wins over clear
    if (men_rd || (cfg_wr && (reg_wdata_in[CFG_MODE_LO +: 2] != 2'b00))) begin
      n.conversion_ready_flag = 1'b0;
    end
    if (run_done) begin
      n.conversion_ready_flag = 1'b1;
    end
    // Open drain: pull low when asserted low, or when idle with active high
    n.alert_oe = q.men[MEN_ALERT_POLARITY] ? !alert_act : alert_act;
    // Read data, unmapped offsets read zero
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CONFIG: n.rdata = q.cfg;
        ADDR_SHUNT:  n.rdata = q.shunt_reg;
        ADDR_BUS:    n.rdata = q.bus_reg;
        ADDR_POWER:  n.rdata = q.pwr_reg;
        ADDR_CURR:   n.rdata = q.cur_reg;
        ADDR_CAL:    n.rdata = q.cal;
        ADDR_MEN:    n.rdata = q.men | (16'(q.aff) << MEN_AFF) | (16'(q.conversion_ready_flag) << MEN_CONVERSION_READY_FLAG);
        ADDR_LIMIT:  n.rdata = q.limit;
        default:     n.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q           <= '0;
      q.state     <= ST_SHUNT;
      q.ct_cnt    <= ct_cycles(CFG_RESET[CFG_SHCT_LO +: 3]);
      q.cfg       <= CFG_RESET;
      q.cal       <= CAL_RESET;
      q.limit     <= LIMIT_RESET;
      q.men       <= MEN_RESET;
      q.alert_oe  <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign reg_rdata_out    = q.rdata;
  assign adc_busy_out     = (q.state != ST_IDLE);
  assign adc_chan_bus_out = (q.state == ST_BUS);
  assign alert_pin_out    = 1'b0;
  assign alert_pin_oe_out = q.alert_oe;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_cur_uncal: assert property (shunt_end && q.cal == 16'h0000 |=> q.last_cur == 16'h0000)
    else $error("current not zero without calibration");
  a_pwr_uncal: assert property (run_done && bus_end && q.cal == 16'h0000 && q.acc_pwr == '0
                                && avg_sh == 4'h0 |=> q.pwr_reg == 16'h0000)
    else $error("power not zero without calibration");
  a_avg_direct: assert property (run_done && bus_end && avg_sh == 4'h0
                                 |=> q.bus_reg == $past(adc_result_in))
    else $error("single sample not loaded directly");
  a_check_prio: assert property (shunt_end && q.men[MEN_SOL] && q.men[MEN_SUL] && !q.men[MEN_LEN]
                                 && $signed(adc_result_in) > $signed(q.limit) |=> q.aff)
    else $error("over-limit check lost priority");
  a_ready_on_alert_enable_off: assert property (!q.men[MEN_READY_ON_ALERT_ENABLE] && !q.aff |=> alert_pin_oe_out == $past(q.men[MEN_ALERT_POLARITY]))
    else $error("alert driven without enabled cause");
  a_latch_hold: assert property (q.men[MEN_LEN] && q.aff && !cfg_wr && !men_rd |=> q.aff)
    else $error("latched flag dropped");
  a_bus_check: assert property (bus_end && sel_bol && !q.men[MEN_LEN] && adc_result_in > q.limit
                                |=> q.aff ##1 alert_pin_oe_out == !$past(q.men[MEN_ALERT_POLARITY]))
    else $error("bus over-limit not flagged");
  a_conv_time: assert property (q.state == ST_SHUNT && q.ct_cnt != '0 && !cfg_wr |=> q.state == ST_SHUNT)
    else $error("shunt conversion cut short");
  a_conversion_ready_flag_set: assert property (run_done |=> q.conversion_ready_flag ##1 (q.conversion_ready_flag || $past(men_rd) || $past(cfg_wr)))
    else $error("ready flag not set at run end");

  // Per-check flag setting, flag clearing and the shared pin
  a_ready_pin: assert property (q.men[MEN_READY_ON_ALERT_ENABLE] && q.conversion_ready_flag && !q.men[MEN_ALERT_POLARITY] |=> alert_pin_oe_out)
    else $error("ready not shown on alert pin");
  a_shunt_under: assert property (shunt_end && sel_sul && !q.men[MEN_LEN]
                                  && $signed(adc_result_in) < $signed(q.limit) |=> q.aff)
    else $error("shunt under-limit not flagged");
  a_pol_check: assert property (bus_end && sel_pol && !q.men[MEN_LEN] && pwr_calc > q.limit |=> q.aff)
    else $error("power over-limit not flagged");
  a_unlatch_drop: assert property (bus_end && sel_bol && !q.men[MEN_LEN] && adc_result_in <= q.limit
                                   |=> !q.aff)
    else $error("unlatched flag kept after clean compare");
  a_conversion_ready_flag_clear: assert property (men_rd && !run_done |=> !q.conversion_ready_flag)
    else $error("ready flag survived mask read");
  a_cfg_clear: assert property (cfg_wr && q.men[MEN_LEN] && !cmp_valid |=> !q.aff)
    else $error("latched flag survived configuration write");

  // Main scenarios reached
  c_run_done: cover property (run_done ##1 q.conversion_ready_flag);
  c_aff_rise: cover property (!q.aff ##1 q.aff);
  c_trig_idle: cover property (q.state == ST_BUS ##1 q.state == ST_IDLE);
  c_latch_read: cover property (q.men[MEN_LEN] && q.aff && men_rd ##1 !q.aff);
  c_avg_four: cover property (run_done && avg_sh == 4'h2);

endmodule

// *** bench/pmca_adc_model.sv ***
// Behavioural model of the converter front end that feeds the calculation block
module pmca_adc_model (
  input  wire logic        clk_in,
  input  wire logic        busy_in,
  input  wire logic        chan_bus_in,
  input  wire logic [15:0] shunt_val_in,
  input  wire logic [15:0] bus_val_in,
  input  wire logic [15:0] step_in,
  output logic      [15:0] result_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        chan_q = 1'b0;
  logic        odd_q  = 1'b0;
  logic [15:0] last_q = 16'h0000;

  // Every second shunt conversion adds the step, so averaging becomes visible
  always_ff @(posedge clk_in) begin
    chan_q <= chan_bus_in;
    if (chan_bus_in && !chan_q) odd_q <= !odd_q;
    if (busy_in) last_q <= result_out;
  end

  // Idle converter shows no stale result, only its inverse
  always_comb begin
    if (!busy_in) result_out = ~last_q;
    else if (chan_bus_in) result_out = bus_val_in;
    else result_out = shunt_val_in + (odd_q ? step_in : 16'h0000);
  end
endmodule

// *** bench/tb.sv ***
// Self-checking testbench of the power monitor calculation and alert block
module tb
  import pmca_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals, rows and instances
  localparam logic [15:0] CFG_RUN  = 16'h0007;
  localparam logic [15:0] CFG_SLOW = 16'h000F;
  localparam logic [15:0] CFG_AVG4 = 16'h0207;
  localparam int          NROW     = 12;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] limit;
    logic [15:0] cal;
    logic [15:0] sh;
    logic [15:0] bus;
    logic        pin;
    logic        aff;
  } pmca_row_type;

  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] sh_val    = 16'h0000;
  logic [15:0] bus_val   = 16'h0000;
  logic [15:0] step      = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] adc_result;
  logic        adc_busy;
  logic        adc_chan_bus;
  logic        alert_pin;
  logic        alert_oe;
  logic        pin_level;
  logic [15:0] rd_val;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cyc_cnt         = 0;
  int          n;

  // Mask, limit, cal, shunt, bus, expected pin level, alert flag
  pmca_row_type rows [NROW] = '{
    '{16'h0000, 16'h0000, 16'h0000, 16'h1F40, 16'h2570, 1'b1, 1'b0},
    '{16'h0000, 16'h0000, 16'h0A00, 16'h1F40, 16'h2570, 1'b1, 1'b0},
    '{16'h0000, 16'h0000, 16'h0A00, 16'hE0C0, 16'h2570, 1'b1, 1'b0},
    '{16'hC000, 16'h0064, 16'h0800, 16'h00C8, 16'h4000, 1'b0, 1'b1},
    '{16'h4000, 16'h0064, 16'h0800, 16'h00C8, 16'h4000, 1'b1, 1'b0},
    '{16'h4000, 16'h0064, 16'h0800, 16'hFFFB, 16'h4000, 1'b0, 1'b1},
    '{16'h2000, 16'h0190, 16'h0800, 16'h00C8, 16'h01F4, 1'b0, 1'b1},
    '{16'h1000, 16'h0190, 16'h0800, 16'h00C8, 16'h01F4, 1'b1, 1'b0},
    '{16'h0002, 16'h0190, 16'h0800, 16'h00C8, 16'h01F4, 1'b0, 1'b0},
    '{16'h0400, 16'h0190, 16'h0800, 16'h00C8, 16'h01F4, 1'b0, 1'b0},
    '{16'h0800, 16'h0064, 16'h0800, 16'h00C8, 16'h4000, 1'b0, 1'b1},
    '{16'h2002, 16'h0190, 16'h0800, 16'h00C8, 16'h01F4, 1'b1, 1'b1}
  };

  // Clock and open-drain pin with its pull-up
  always #10 clk_sys = ~clk_sys;
  assign pin_level = alert_oe ? alert_pin : 1'b1;

  pmca_core #(.CYC_PER_US(1)) u_dut (
    .clk_sys_in       (clk_sys),
    .rst_n_in         (rst_n),
    .reg_addr_in      (reg_addr),
    .reg_wdata_in     (reg_wdata),
    .reg_wr_in        (reg_wr),
    .reg_rd_in        (reg_rd),
    .reg_rdata_out    (reg_rdata),
    .adc_result_in    (adc_result),
    .adc_busy_out     (adc_busy),
    .adc_chan_bus_out (adc_chan_bus),
    .alert_pin_out    (alert_pin),
    .alert_pin_oe_out (alert_oe)
  );

  pmca_adc_model u_adc (
    .clk_in       (clk_sys),
    .busy_in      (adc_busy),
    .chan_bus_in  (adc_chan_bus),
    .shunt_val_in (sh_val),
    .bus_val_in   (bus_val),
    .step_in      (step),
    .result_out   (adc_result)
  );

  // ==========================================================================
  // Tasks and reference arithmetic
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    wait_cyc(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    wait_cyc(1);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask

  task automatic count_chan(input logic lvl, output int c);
    c = 0;
    while (adc_chan_bus === lvl && c < 9000) begin
      c++;
      wait_cyc(1);
    end
  endtask

  function automatic logic [15:0] cur_of(input logic [15:0] sh, input logic [15:0] cal);
    logic signed [33:0] p;
    p = ($signed(sh) * $signed({1'b0, cal})) >>> 11;
    if (cal == 16'h0000) p = '0;
    if (p > 34'sd32767) p = 34'sd32767;
    if (p < -34'sd32768) p = -34'sd32768;
    return p[15:0];
  endfunction

  function automatic logic [15:0] pwr_of(input logic [15:0] cur, input logic [15:0] bus);
    logic [15:0] m;
    logic [31:0] p;
    m = cur[15] ? 16'h0000 - cur : cur;
    p = (32'(m) * 32'(bus)) >> 14;
    return (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  task automatic end_sim();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard on a cycle ceiling well above the expected run
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    wait_cyc(8);
    rst_n = 1'b1;
    rd_chk(ADDR_CONFIG, CFG_RESET);
    rd_chk(ADDR_CAL, CAL_RESET);
    rd_chk(ADDR_LIMIT, LIMIT_RESET);
    rd_chk(ADDR_MEN, MEN_RESET);
    rd_chk(8'h08, 16'h0000);
    reg_wr_t(ADDR_SHUNT, 16'h1234);
    rd_chk(ADDR_SHUNT, 16'h0000);
    check({15'h0000, pin_level}, 16'h0001);
    $display("Test reset done");
    // Table of single-sample runs
    for (int i = 0; i < NROW; i++) begin
      sh_val = rows[i].sh;
      bus_val = rows[i].bus;
      reg_wr_t(ADDR_MEN, rows[i].mask);
      reg_wr_t(ADDR_LIMIT, rows[i].limit);
      reg_wr_t(ADDR_CAL, rows[i].cal);
      reg_wr_t(ADDR_CONFIG, CFG_RUN);
      wait_cyc(300);
      check({15'h0000, pin_level}, {15'h0000, rows[i].pin});
      rd_chk(ADDR_SHUNT, rows[i].sh);
      rd_chk(ADDR_BUS, rows[i].bus);
      rd_chk(ADDR_CURR, cur_of(rows[i].sh, rows[i].cal));
      rd_chk(ADDR_POWER, pwr_of(cur_of(rows[i].sh, rows[i].cal), rows[i].bus));
      rd_chk(ADDR_MEN, (rows[i].mask & MEN_WR_MASK) | {11'h000, rows[i].aff, 4'h8});
      $display("Test row %0d done", i);
    end
    // Independent shunt and bus conversion lengths, then the next shunt
    reg_wr_t(ADDR_CONFIG, CFG_SLOW);
    count_chan(1'b0, n);
    check(16'(n), 16'h00CC);
    count_chan(1'b1, n);
    check(16'(n), 16'h008C);
    check({14'h0000, adc_busy, adc_chan_bus}, 16'h0002);
    $display("Test conversion timing done");
    // Unlatched then latched alert, violation removed before the check
    for (int l = 0; l < 2; l++) begin
      sh_val = 16'h00C8;
      bus_val = 16'h01F4;
      reg_wr_t(ADDR_MEN, 16'h2000 | 16'(l));
      reg_wr_t(ADDR_LIMIT, 16'h0190);
      reg_wr_t(ADDR_CONFIG, CFG_RUN);
      wait_cyc(300);
      bus_val = 16'h012C;
      wait_cyc(300);
      check({15'h0000, pin_level}, 16'(1 - l));
      rd_chk(ADDR_MEN, 16'h2008 | ((l == 1) ? 16'h0011 : 16'h0000));
      wait_cyc(3);
      check({15'h0000, pin_level}, 16'h0001);
      rd_chk(ADDR_MEN, 16'h2000 | 16'(l));
      $display("Test alert latch %0d done", l);
    end
    // Four-sample averaging with alternating shunt samples
    reg_wr_t(ADDR_MEN, 16'h0000);
    sh_val = 16'h0064;
    bus_val = 16'h4000;
    step = 16'h0004;
    reg_wr_t(ADDR_CAL, 16'h0800);
    reg_wr_t(ADDR_CONFIG, CFG_AVG4);
    wait_cyc(600);
    rd_chk(ADDR_SHUNT, 16'h00C8);
    rd_chk(ADDR_MEN, 16'h0000);
    wait_cyc(540);
    rd_chk(ADDR_SHUNT, 16'h0066);
    rd_chk(ADDR_BUS, 16'h4000);
    rd_chk(ADDR_CURR, 16'h0066);
    rd_chk(ADDR_POWER, 16'h0066);
    rd_chk(ADDR_MEN, 16'h0008);
    $display("Test averaging done");
    end_sim();
  end
endmodule
